// ---- logic/bts_cmd_handler.sv ----
/*
 * Bias-trim and save command line handler.
 * Assumes one character per strobe, a formatter taking one token per
 * cycle, and a store that holds off the request until its done strobe.
 */
// How it works
// RQ1 - Three-parameter form touches only named axis
// RQ2 - Unknown command line answers E001
// RQ3 - Trim parameter count or early comma: E002
// RQ4 - Out-of-range parameter value answers E003
// RQ5 - Clamp applied, offsets listed, then E008
// RQ6 - Confirmed save writes configuration to memory
// RQ7 - Save asks confirmation, needs upper-case Y
// RQ8 - Save counter above limit warns E004
// RQ9 - Save always attempted whatever the count
// RQ10 - Unconfirmed save reverts changed link settings
// RQ11 - Failed memory write answers E005
// RQ12 - Characters after save letter answer E002
// RQ13 - Success message carries the save count
// RQ14 - Answer N aborts without writing memory
// RQ15 - Other answer aborts, then E003
// RQ16 - Ready prompt only after save finished
// RQ17 - Confirmation says change is permanent, asks
// RQ18 - Three-parameter form adds delta to offset
// RQ19 - Out-of-range trim replaced by nearest limit
`default_nettype none

module bts_cmd_handler
   import bts_pkg::*;
(
   input  wire logic                 clock_i,         // System clock
   input  wire logic                 sys_rst_i,       // Sync reset, high
   input  wire logic                 rx_valid_i,      // Character strobe
   input  wire logic [7:0]           rx_data_i,       // ASCII character
   input  wire logic                 tx_changed_i,    // Link settings dirty
   input  wire logic                 nvm_done_i,      // Write finished
   input  wire logic                 nvm_fail_i,      // Write failed
   output logic                      resp_valid_o,    // Token strobe
   output bts_resp_type              resp_o,          // Response token
   output logic                      busy_o,          // Line in progress
   output logic                      nvm_write_o,     // Write request
   output logic                      tx_revert_o,     // Restore link pulse
   output logic      [BTS_CNT_W-1:0] save_count_o,    // Saves done
   output logic [BTS_N_OFS-1:0][BTS_VAL_W-1:0] bias_o // Trim offsets
);

   typedef enum logic [3:0] {
      S_IDLE, S_SP, S_NUM, S_SENS, S_SEPA, S_AXIS, S_END,
      S_LIST, S_SCR, S_ANS, S_NVM, S_SKIP, S_TAIL
   } bts_state_type;

   bts_state_type            state;
   logic                     neg;
   logic [1:0]               sens;
   logic [1:0]               axis;
   logic [1:0]               nparam;
   logic [3:0]               idx;
   logic                     hit_limit;
   logic [7:0]               ans;
   logic [1:0]               ans_len;
   bts_rsp_code_type         tok_a;
   bts_rsp_code_type         tok_b;
   logic [BTS_VAL_W-1:0]     tok_a_val;

   logic                     is_digit;
   logic                     acc_clear;
   logic                     acc_en;
   logic [BTS_MAG_W-1:0]     mag;
   logic [2:0]               ndig;
   logic                     ovf;
   logic signed [BTS_VAL_W-1:0] req_val;
   logic [1:0]               idx_sens;
   logic [1:0]               idx_axis;
   logic                     selected;
   logic signed [BTS_VAL_W-1:0] new_ofs;
   logic                     clamped;
   logic [BTS_CNT_W-1:0]     next_count;
   logic                     line_end;

   assign is_digit  = rx_data_i >= BTS_CH_ZERO && rx_data_i <= BTS_CH_NINE;
   assign line_end  = rx_valid_i && rx_data_i == BTS_CH_CR;
   assign acc_clear = state == S_SP;
   assign acc_en    = state == S_NUM && rx_valid_i && is_digit;
   assign req_val   = neg ? -BTS_VAL_W'(mag) : BTS_VAL_W'(mag);
   assign next_count = save_count_o + 16'h0001;

   // Offsets are laid out sensor-major: gyro 0..2, acc 3..5, incl. 6..8
   assign idx_sens = (idx >= 4'h6) ? 2'h2 : (idx >= 4'h3) ? 2'h1 : 2'h0;
   assign idx_axis = 2'(idx - {1'b0, idx_sens, 1'b0} - {2'b00, idx_sens});

   always_comb begin
      unique case (nparam)
         2'h1:    selected = 1'b1;
         2'h2:    selected = idx_sens == sens;
         default: selected = idx_sens == sens && idx_axis == axis; // [RQ1]
      endcase
   end

   bts_digit_acc u_digits (
      .clock_i    (clock_i),
      .sys_rst_i  (sys_rst_i),
      .clear_i    (acc_clear),
      .digit_en_i (acc_en),
      .digit_i    (rx_data_i[3:0]),
      .value_o    (mag),
      .count_o    (ndig),
      .overflow_o (ovf)
   );

   bts_clamp u_clamp (
      .base_i    (bias_o[idx]),
      .value_i   (req_val),
      .add_i     (nparam == 2'h3),                            // [RQ18]
      .min_i     (BTS_LIM_MIN[idx_sens]),
      .max_i     (BTS_LIM_MAX[idx_sens]),
      .result_o  (new_ofs),
      .clamped_o (clamped)
   );

   // Line parser and sequencer
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state     <= S_IDLE;
         neg       <= 1'b0;
         sens      <= 2'h0;
         axis      <= 2'h0;
         nparam    <= 2'h0;
         idx       <= 4'h0;
         hit_limit <= 1'b0;
         ans       <= 8'h00;
         ans_len   <= 2'h0;
         tok_a     <= BTS_RSP_NONE;
         tok_b     <= BTS_RSP_NONE;
         tok_a_val <= '0;
      end else begin
         unique case (state)
            S_IDLE: if (rx_valid_i) begin
               tok_a <= BTS_RSP_NONE;
               tok_b <= BTS_RSP_NONE;
               neg   <= 1'b0;
               tok_a_val <= '0;
               if (rx_data_i == BTS_CH_TRIM) begin
                  state <= S_SP;
               end else if (rx_data_i == BTS_CH_SAVE) begin
                  state <= S_SCR;
               end else if (rx_data_i == BTS_CH_CR) begin
                  state <= S_TAIL;
               end else begin
                  tok_a <= BTS_RSP_E001;                      // [RQ2]
                  state <= S_SKIP;
               end
            end
            S_SP: if (rx_valid_i) begin
               if (rx_data_i == BTS_CH_SP) begin
                  state <= S_NUM;
               end else if (rx_data_i == BTS_CH_COMMA) begin
                  tok_a <= BTS_RSP_E002;                      // [RQ3]
                  state <= S_SKIP;
               end else if (rx_data_i == BTS_CH_CR) begin
                  tok_a <= BTS_RSP_E002;                      // [RQ3]
                  state <= S_TAIL;
               end else begin
                  tok_a <= BTS_RSP_E001;                      // [RQ2]
                  state <= S_SKIP;
               end
            end
            S_NUM: if (rx_valid_i) begin
               if (ovf) begin
                  tok_a <= BTS_RSP_E003;                      // [RQ4]
                  state <= line_end ? S_TAIL : S_SKIP;
               end else if (is_digit) begin
                  state <= S_NUM;
               end else if (rx_data_i == BTS_CH_MINUS && ndig == 3'h0
                            && !neg) begin
                  neg <= 1'b1;
               end else if (ndig == 3'h0 && (rx_data_i == BTS_CH_COMMA
                            || line_end)) begin
                  tok_a <= BTS_RSP_E002;                      // [RQ3]
                  state <= line_end ? S_TAIL : S_SKIP;
               end else if (rx_data_i == BTS_CH_COMMA) begin
                  state <= S_SENS;
               end else if (line_end) begin
                  nparam <= 2'h1;
                  idx    <= 4'h0;
                  state  <= S_LIST;
               end else begin
                  tok_a <= BTS_RSP_E003;                      // [RQ4]
                  state <= S_SKIP;
               end
            end
            S_SENS: if (rx_valid_i) begin
               state <= S_SEPA;
               if (rx_data_i == BTS_CH_GYRO) begin
                  sens <= 2'h0;
               end else if (rx_data_i == BTS_CH_ACC) begin
                  sens <= 2'h1;
               end else if (rx_data_i == BTS_CH_INC) begin
                  sens <= 2'h2;
               end else if (rx_data_i == BTS_CH_COMMA || line_end) begin
                  tok_a <= BTS_RSP_E002;                      // [RQ3]
                  state <= line_end ? S_TAIL : S_SKIP;
               end else begin
                  tok_a <= BTS_RSP_E003;                      // [RQ4]
                  state <= S_SKIP;
               end
            end
            S_SEPA: if (rx_valid_i) begin
               if (rx_data_i == BTS_CH_COMMA) begin
                  state <= S_AXIS;
               end else if (line_end) begin
                  nparam <= 2'h2;
                  idx    <= 4'h0;
                  state  <= S_LIST;
               end else begin
                  tok_a <= BTS_RSP_E002;                      // [RQ3]
                  state <= S_SKIP;
               end
            end
            S_AXIS: if (rx_valid_i) begin
               state <= S_END;
               if (rx_data_i == BTS_CH_X) begin
                  axis <= 2'h0;
               end else if (rx_data_i == BTS_CH_Y) begin
                  axis <= 2'h1;
               end else if (rx_data_i == BTS_CH_Z) begin
                  axis <= 2'h2;
               end else if (line_end) begin
                  tok_a <= BTS_RSP_E002;                      // [RQ3]
                  state <= S_TAIL;
               end else begin
                  tok_a <= BTS_RSP_E003;                      // [RQ4]
                  state <= S_SKIP;
               end
            end
            S_END: if (rx_valid_i) begin
               if (line_end) begin
                  nparam <= 2'h3;
                  idx    <= 4'h0;
                  state  <= S_LIST;
               end else begin
                  tok_a <= BTS_RSP_E002;                      // [RQ3]
                  state <= S_SKIP;
               end
            end
            S_LIST: begin
               // One offset per cycle; E008 is queued behind the list
               if (selected && clamped) begin
                  hit_limit <= 1'b1;
               end
               if (idx == BTS_LAST_IDX) begin
                  tok_a <= (hit_limit || (selected && clamped))
                           ? BTS_RSP_E008 : BTS_RSP_NONE;     // [RQ5]
                  hit_limit <= 1'b0;
                  state     <= S_TAIL;
               end else begin
                  idx <= idx + 4'h1;
               end
            end
            S_SCR: if (rx_valid_i) begin
               if (line_end) begin
                  ans_len <= 2'h0;
                  state   <= S_ANS;
               end else begin
                  tok_a <= BTS_RSP_E002;                      // [RQ12]
                  state <= S_SKIP;
               end
            end
            S_ANS: if (rx_valid_i) begin
               if (!line_end) begin
                  ans <= rx_data_i;
                  if (ans_len != 2'h2) begin
                     ans_len <= ans_len + 2'h1;
                  end
               end else if (ans_len == 2'h1 && ans == BTS_CH_YES) begin
                  state <= S_NVM;                             // [RQ7]
               end else begin
                  tok_a <= BTS_RSP_ABORTED;                   // [RQ14]
                  tok_b <= (ans_len == 2'h1 && ans == BTS_CH_NO)
                           ? BTS_RSP_NONE : BTS_RSP_E003;     // [RQ15]
                  state <= S_TAIL;
               end
            end
            S_NVM: if (nvm_done_i) begin
               if (nvm_fail_i) begin
                  tok_a <= BTS_RSP_E005;                      // [RQ11]
               end else begin
                  tok_a     <= BTS_RSP_SAVED;                 // [RQ13]
                  tok_a_val <= BTS_VAL_W'(next_count);
                  tok_b     <= (next_count > BTS_SAVE_LIMIT)
                               ? BTS_RSP_E004 : BTS_RSP_NONE; // [RQ8]
               end
               state <= S_TAIL;                               // [RQ16]
            end
            S_SKIP: if (line_end) begin
               state <= S_TAIL;
            end
            S_TAIL: begin
               // Drain queued tokens, prompt goes last
               if (tok_a != BTS_RSP_NONE) begin
                  tok_a <= BTS_RSP_NONE;
               end else if (tok_b != BTS_RSP_NONE) begin
                  tok_b <= BTS_RSP_NONE;
               end else begin
                  state <= S_IDLE;
               end
            end
         endcase
      end
   end

   // Response token output
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         resp_valid_o <= 1'b0;
         resp_o       <= '0;
      end else begin
         resp_valid_o <= 1'b0;
         resp_o       <= '0;
         if (state == S_LIST && selected) begin
            resp_valid_o <= 1'b1;
            resp_o       <= '{BTS_RSP_OFFSET, idx, new_ofs};
         end else if (state == S_SCR && line_end) begin
            resp_valid_o <= 1'b1;
            resp_o.code  <= BTS_RSP_CONFIRM;                  // [RQ17]
         end else if (state == S_TAIL) begin
            resp_valid_o <= 1'b1;
            if (tok_a != BTS_RSP_NONE) begin
               resp_o <= '{tok_a, 4'h0, tok_a_val};
            end else if (tok_b != BTS_RSP_NONE) begin
               resp_o.code <= tok_b;
            end else begin
               resp_o.code <= BTS_RSP_PROMPT;                 // [RQ16]
            end
         end
      end
   end

   // Trim offsets; clamp result written only to selected entries
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         bias_o <= {BTS_N_OFS{BTS_OFS_RESET}};
      end else if (state == S_LIST && selected) begin
         bias_o[idx] <= new_ofs;                              // [RQ19]
      end
   end

   // Store request: raised on the CR after a lone Y, held until the store answers
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         nvm_write_o <= 1'b0;
      end else if (state == S_ANS && line_end && ans_len == 2'h1
                   && ans == BTS_CH_YES) begin
         nvm_write_o <= 1'b1;                                 // [RQ6] [RQ9]
      end else if (state == S_NVM && nvm_done_i) begin
         nvm_write_o <= 1'b0;
      end
   end

   // Counter keeps running past the limit and holds at 16'hffff; the limit only drives the warning
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         save_count_o <= BTS_CNT_RESET;
      end else if (state == S_NVM && nvm_done_i && !nvm_fail_i
                   && save_count_o != 16'hffff) begin
         save_count_o <= next_count;                          // [RQ8]
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         tx_revert_o <= 1'b0;
      end else begin
         tx_revert_o <= state == S_ANS && line_end && tx_changed_i
                        && !(ans_len == 2'h1 && ans == BTS_CH_YES); // [RQ10]
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= state != S_IDLE;
      end
   end

endmodule : bts_cmd_handler

`default_nettype wire

// ---- include/bts_pkg.sv ----
/*
 * Constants, response codes and carriers of the command handler.
 * Assumes 8-bit ASCII characters.
 */
`default_nettype none

package bts_pkg;

   // Character codes of the command language
   localparam logic [7:0] BTS_CH_TRIM  = 8'h62;
   localparam logic [7:0] BTS_CH_SAVE  = 8'h73;
   localparam logic [7:0] BTS_CH_SP    = 8'h20;
   localparam logic [7:0] BTS_CH_COMMA = 8'h2c;
   localparam logic [7:0] BTS_CH_CR    = 8'h0d;
   localparam logic [7:0] BTS_CH_MINUS = 8'h2d;
   localparam logic [7:0] BTS_CH_ZERO  = 8'h30;
   localparam logic [7:0] BTS_CH_NINE  = 8'h39;
   localparam logic [7:0] BTS_CH_GYRO  = 8'h67;
   localparam logic [7:0] BTS_CH_ACC   = 8'h61;
   localparam logic [7:0] BTS_CH_INC   = 8'h69;
   localparam logic [7:0] BTS_CH_X     = 8'h78;
   localparam logic [7:0] BTS_CH_Y     = 8'h79;
   localparam logic [7:0] BTS_CH_Z     = 8'h7a;
   localparam logic [7:0] BTS_CH_YES   = 8'h59;
   localparam logic [7:0] BTS_CH_NO    = 8'h4e;

   // Offset storage: three sensors of three axes each
   localparam int          BTS_VAL_W     = 24;
   localparam int          BTS_MAG_W     = 20;
   localparam int          BTS_N_OFS     = 9;
   localparam logic [2:0]  BTS_MAX_DIGITS = 3'h6;
   localparam logic [3:0]  BTS_LAST_IDX  = 4'h8;
   localparam logic [BTS_VAL_W-1:0] BTS_OFS_RESET = 24'h000000;

   // Trim limits in offset LSBs, per sensor (gyro, accelerometer, incl.)
   localparam logic signed [BTS_VAL_W-1:0] BTS_LIM_MAX [3] =
      '{24'sh004e20, 24'sh004e20, 24'sh004e20};
   localparam logic signed [BTS_VAL_W-1:0] BTS_LIM_MIN [3] =
      '{-24'sh004e20, -24'sh004e20, -24'sh004e20};

   // Save counter and its wear limit
   localparam int          BTS_CNT_W     = 16;
   localparam logic [15:0] BTS_SAVE_LIMIT = 16'h2710;
   localparam logic [15:0] BTS_CNT_RESET = 16'h0000;

   typedef enum logic [3:0] {
      BTS_RSP_NONE,
      BTS_RSP_OFFSET,
      BTS_RSP_CONFIRM,
      BTS_RSP_SAVED,
      BTS_RSP_ABORTED,
      BTS_RSP_PROMPT,
      BTS_RSP_E001,
      BTS_RSP_E002,
      BTS_RSP_E003,
      BTS_RSP_E004,
      BTS_RSP_E005,
      BTS_RSP_E008
   } bts_rsp_code_type;

   typedef struct packed {
      bts_rsp_code_type       code;
      logic [3:0]             index;
      logic [BTS_VAL_W-1:0]   value;
   } bts_resp_type;

endpackage : bts_pkg

`default_nettype wire

// ---- logic/bts_digit_acc.sv ----
/*
 * Decimal digit accumulator for a trim magnitude.
 * Assumes digits arrive most significant first.
 */
`default_nettype none

module bts_digit_acc
   import bts_pkg::*;
(
   input  wire logic                 clock_i,      // System clock
   input  wire logic                 sys_rst_i,    // Sync reset, high
   input  wire logic                 clear_i,      // Restart the number
   input  wire logic                 digit_en_i,   // Take one digit
   input  wire logic [3:0]           digit_i,      // Digit value 0..9
   output logic      [BTS_MAG_W-1:0] value_o,      // Magnitude so far
   output logic      [2:0]           count_o,      // Digits taken
   output logic                      overflow_o    // Too many digits
);

   logic [BTS_MAG_W-1:0] next_value;

   // Times ten as two shifts, so no multiplier is inferred
   assign next_value = BTS_MAG_W'({value_o, 3'b000})
                     + BTS_MAG_W'({value_o, 1'b0})
                     + BTS_MAG_W'(digit_i);

   always_ff @(posedge clock_i) begin
      if (sys_rst_i || clear_i) begin
         value_o    <= '0;
         count_o    <= 3'h0;
         overflow_o <= 1'b0;
      end else if (digit_en_i) begin
         if (count_o == BTS_MAX_DIGITS) begin
            overflow_o <= 1'b1;
         end else begin
            value_o <= next_value;
            count_o <= count_o + 3'h1;
         end
      end
   end

endmodule : bts_digit_acc

`default_nettype wire

// ---- logic/bts_clamp.sv ----
/*
 * Adds or sets a trim offset, limited to a min/max window.
 * Combinational; assumes min is not above max.
 */
`default_nettype none

module bts_clamp
   import bts_pkg::*;
(
   input  wire logic signed [BTS_VAL_W-1:0] base_i,    // Present offset
   input  wire logic signed [BTS_VAL_W-1:0] value_i,   // Request
   input  wire logic                        add_i,     // Add, else set
   input  wire logic signed [BTS_VAL_W-1:0] min_i,     // Lower limit
   input  wire logic signed [BTS_VAL_W-1:0] max_i,     // Upper limit
   output logic      signed [BTS_VAL_W-1:0] result_o,  // Limited value
   output logic                             clamped_o  // Limit was hit
);

   logic signed [BTS_VAL_W:0] sum;

   // One extra bit so a wrapping sum cannot slip past the limits
   assign sum = (BTS_VAL_W+1)'(value_i)
              + (add_i ? (BTS_VAL_W+1)'(base_i) : (BTS_VAL_W+1)'(0));

   always_comb begin
      result_o  = BTS_VAL_W'(sum);
      clamped_o = 1'b0;
      if (sum > max_i) begin
         result_o  = max_i;
         clamped_o = 1'b1;
      end else if (sum < min_i) begin
         result_o  = min_i;
         clamped_o = 1'b1;
      end
   end

endmodule : bts_clamp

`default_nettype wire

// ---- tb/bts_cmd_handler_asserts.sv ----
/* Port checker for the command handler.
   Assumes a bind from tb_top. */
`default_nettype none
module bts_cmd_handler_asserts
   import bts_pkg::*;
(
   input wire logic                 clock_i,      // Clock
   input wire logic                 sys_rst_i,    // Reset
   input wire logic                 rx_valid_i,   // Char strobe
   input wire logic [7:0]           rx_data_i,    // Char
   input wire logic                 nvm_done_i,   // Store done
   input wire logic                 nvm_fail_i,   // Store failed
   input wire logic                 resp_valid_o, // Token strobe
   input wire bts_resp_type         resp_o,       // Token
   input wire logic                 nvm_write_o,  // Write request
   input wire logic                 tx_revert_o,  // Revert pulse
   input wire logic [BTS_CNT_W-1:0] save_count_o  // Save count
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   logic cr_taken;
   logic done_ok;
   assign cr_taken = rx_valid_i && (rx_data_i == BTS_CH_CR);
   assign done_ok  = nvm_write_o && nvm_done_i && !nvm_fail_i;
   AST_WRITE_HELD :
   assert property (nvm_write_o && !nvm_done_i |=> nvm_write_o)
      else $error("write dropped");
   AST_WRITE_START :
   assert property ($rose(nvm_write_o) |-> $past(cr_taken))
      else $error("stray write");
   AST_COUNT_STEP :
   assert property ($changed(save_count_o) |-> $past(done_ok)
      && save_count_o == $past(save_count_o) + 16'h0001)
      else $error("bad count step");
   AST_FAIL_E005 :
   assert property (nvm_write_o && nvm_done_i && nvm_fail_i
      |-> ##[1:4] (resp_valid_o && resp_o.code == BTS_RSP_E005))
      else $error("no E005");
   AST_NO_EARLY_PROMPT :
   assert property (nvm_write_o
      |-> !(resp_valid_o && resp_o.code == BTS_RSP_PROMPT))
      else $error("early prompt");
   AST_SAVED_TOKEN :
   assert property (done_ok
      |-> ##[1:4] (resp_valid_o && resp_o.code == BTS_RSP_SAVED))
      else $error("no saved token");
   AST_REVERT_CAUSE :
   assert property (tx_revert_o |-> $past(cr_taken) && !nvm_write_o)
      else $error("stray revert");
   AST_CONFIRM_CAUSE :
   assert property (resp_valid_o && resp_o.code == BTS_RSP_CONFIRM
      |-> $past(cr_taken))
      else $error("stray confirm");
endmodule : bts_cmd_handler_asserts
`default_nettype wire

// ---- tb/bts_nvm_model.sv ----
/* Store model: answers a write delay_i+1 cycles after it is raised.
   Assumes the request is held until done. */
`default_nettype none
module bts_nvm_model (
   input  wire logic       clock_i,   // Clock
   input  wire logic       sys_rst_i, // Reset
   input  wire logic       write_i,   // Write request
   input  wire logic [7:0] delay_i,   // Answer delay
   input  wire logic       fail_i,    // Report failure
   output logic            done_o,    // Done pulse
   output logic            fail_o     // Failure flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   logic       fire;
   assign fire = write_i && !done_o && (cnt == delay_i);
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !write_i || done_o) begin
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
   always_ff @(posedge clock_i) begin
      done_o <= !sys_rst_i && fire;
      // Only meaningful with done
      fail_o <= sys_rst_i ? 1'b0 : (fire ? fail_i : ~fail_o);
   end
endmodule : bts_nvm_model
`default_nettype wire

// ---- tb/tb_top.sv ----
/* Bench: sends command lines, judges tokens.
   Assumes the store model and the bound checker. */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bts_pkg::*;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic rx_valid_i = 1'b0;
   logic [7:0] rx_data_i = 8'h00;
   logic tx_changed_i = 1'b0;
   logic fail_mode = 1'b0;
   logic [7:0] delay = 8'h02;
   logic nvm_done, nvm_fail, resp_valid, busy, nvm_write, tx_revert;
   bts_resp_type resp;
   logic [BTS_CNT_W-1:0] save_count;
   logic [BTS_N_OFS-1:0][BTS_VAL_W-1:0] bias;
   bts_resp_type got[$];
   int fail_count = 0;
   int checks_done = 0;
   int reverts = 0;
   int cycles = 0;
   initial forever #2.5 clock_i = ~clock_i;
   bts_cmd_handler i_bts_cmd_handler (.clock_i(clock_i),
      .sys_rst_i(sys_rst_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
      .tx_changed_i(tx_changed_i), .nvm_done_i(nvm_done),
      .nvm_fail_i(nvm_fail), .resp_valid_o(resp_valid), .resp_o(resp),
      .busy_o(busy), .nvm_write_o(nvm_write), .tx_revert_o(tx_revert),
      .save_count_o(save_count), .bias_o(bias));
   bts_nvm_model i_bts_nvm_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .write_i(nvm_write), .delay_i(delay), .fail_i(fail_mode),
      .done_o(nvm_done), .fail_o(nvm_fail));
   task automatic results();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   always @(posedge clock_i) begin
      cycles++;
      if (tx_revert === 1'b1) reverts++;
      if (cycles == 20000) begin
         fail_count++;
         results();
      end
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One line plus CR; gathers tokens to prompt or confirm
   task automatic line(string s);
      got.delete();
      for (int i = 0; i <= s.len(); i++) begin
         @(posedge clock_i);
         rx_valid_i <= 1'b1;
         rx_data_i  <= (i == s.len()) ? BTS_CH_CR : s[i];
      end
      @(posedge clock_i);
      rx_valid_i <= 1'b0;
      for (int n = 0; n < 300; n++) begin
         #1;
         if (resp_valid === 1'b1) got.push_back(resp);
         if (resp_valid === 1'b1 && resp.code inside
            {BTS_RSP_PROMPT, BTS_RSP_CONFIRM}) break;
         @(posedge clock_i);
      end
   endtask : line
   task automatic t_trim();
      line("b 5,g,y");
      chk("offset", {BTS_RSP_OFFSET, 4'h1, 24'h000005}, got[0]);
      chk("tokens", 32'd2, got.size());
      chk("gyro x", 32'h0, bias[0]);
      line("b -7,g,y");
      chk("delta", 32'h00fffffe, bias[1]);
   endtask : t_trim
   task automatic t_clamp();
      line("b 30000,a");
      chk("clamp count", 32'd5, got.size());
      chk("acc z", {BTS_RSP_OFFSET, 4'h5, 24'h004e20}, got[2]);
      chk("clamp flag", BTS_RSP_E008, got[3].code);
      line("b -30000,i,x");
      chk("incl x", 32'h00ffb1e0, bias[6]);
      chk("incl y", 32'h0, bias[7]);
      chk("low flag", BTS_RSP_E008, got[1].code);
   endtask : t_clamp
   task automatic t_errors();
      string ln[7] = '{"q", "b,5", "b", "b 5,q", "b 1234567", "b 1,g,x,y",
         "s 1"};
      bts_rsp_code_type cd[7] = '{BTS_RSP_E001, BTS_RSP_E002, BTS_RSP_E002,
         BTS_RSP_E003, BTS_RSP_E003, BTS_RSP_E002, BTS_RSP_E002};
      foreach (ln[i]) begin
         line(ln[i]);
         chk(ln[i], cd[i], got[0].code);
      end
   endtask : t_errors
   task automatic t_save();
      line("s");
      chk("confirm", BTS_RSP_CONFIRM, got[0].code);
      chk("busy", 32'd1, busy);
      line("Y");
      chk("saved", BTS_RSP_SAVED, got[0].code);
      chk("saved count", 32'd1, got[0].value);
      chk("prompt", BTS_RSP_PROMPT, got[1].code);
      delay <= 8'd20;
      fail_mode <= 1'b1;
      line("s");
      line("Y");
      chk("save error", BTS_RSP_E005, got[0].code);
      chk("count kept", 32'd1, save_count);
   endtask : t_save
   task automatic t_abort();
      tx_changed_i <= 1'b1;
      line("s");
      line("N");
      chk("aborted", BTS_RSP_ABORTED, got[0].code);
      chk("revert", 32'd1, reverts);
      line("s");
      line("y");
      chk("bad answer", BTS_RSP_E003, got[1].code);
      chk("revert again", 32'd2, reverts);
      chk("no write", 32'd1, save_count);
   endtask : t_abort
   initial begin
      repeat (6) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      t_trim();
      t_clamp();
      t_errors();
      t_save();
      t_abort();
      results();
   end
endmodule : tb_top
bind bts_cmd_handler bts_cmd_handler_asserts i_bts_cmd_handler_asserts (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .rx_valid_i(rx_valid_i),
   .rx_data_i(rx_data_i), .nvm_done_i(nvm_done_i), .nvm_fail_i(nvm_fail_i),
   .resp_valid_o(resp_valid_o), .resp_o(resp_o), .nvm_write_o(nvm_write_o),
   .tx_revert_o(tx_revert_o), .save_count_o(save_count_o));
`default_nettype wire
